//--- dv/pxs_sta_model.sv
// station management controller: drives framed mdc/mdio transfers
// assumes a pull-up on the shared mdio line and mdc held low between frames
`timescale 1ns/1ps
module pxs_sta_model (
  input wire logic clk,
  input wire logic dev_out,
  input wire logic dev_oe_n,
  output logic mdc,
  output logic mdio
);
  logic sta_bit = 1'b1;
  logic sta_en = 1'b0;
  // released line floats to the pull-up level, never the last driven bit
  assign mdio = !dev_oe_n ? dev_out : (sta_en ? sta_bit : 1'b1);
  initial mdc = 1'b0;

  task automatic frame(input logic [1:0] op, input logic [4:0] pad, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] bits;
    bits = {32'hFFFF_FFFF, 2'b01, op, pad, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      @(negedge clk);
      // on a read the line is handed over from the turnaround on
      sta_en = (op == pxs_pkg::OP_WRITE) || (i > 17);
      sta_bit = bits[i];
      repeat (5) @(negedge clk);
      mdc = 1'b1;
      if (i < 16) rd = {rd[14:0], mdio};
      repeat (5) @(negedge clk);
      mdc = 1'b0;
    end
    @(negedge clk);
    sta_en = 1'b0;
  endtask
endmodule

//--- dv/tb.sv
// self-checking bench for the extended status register slice
// assumes the controller model owns mdc and mdio; status inputs change on falling edges
`timescale 1ns/1ps
module tb;
  localparam logic [4:0] STRAP = 5'h05;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic mdc;
  logic mdio;
  logic mdio_out;
  logic mdio_oe_n;
  logic page_load = 1'b0;
  logic [3:0] page_code = 4'h0;
  logic speed_100 = 1'b0;
  logic full_duplex = 1'b0;
  logic [2:0] an_progress = 3'h0;
  logic cmd_override_en;
  logic [15:0] rd;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int pulses = 0;

  always #12.5 clk = ~clk;

  pxs_sta_model sta (.clk(clk), .dev_out(mdio_out), .dev_oe_n(mdio_oe_n), .mdc(mdc),
    .mdio(mdio));
  pxs_status_regs dut (.clk(clk), .reset(reset), .mdc(mdc), .mdio_in(mdio),
    .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .phy_addr_strap(STRAP),
    .page_load(page_load), .page_code(page_code), .speed_100(speed_100),
    .full_duplex(full_duplex), .an_progress(an_progress),
    .cmd_override_en(cmd_override_en));

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // hang guard well above the roughly 20000 cycles the frames need
  always @(posedge clk) begin
    cycles++;
    if (cmd_override_en === 1'b1) pulses++;
    if (cycles == 60000) begin
      err_count++;
      close_out();
    end
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic rd_reg(input logic [4:0] ra, output logic [15:0] d);
    sta.frame(pxs_pkg::OP_READ, STRAP, ra, 16'h0000, d);
  endtask

  task automatic wr_reg(input logic [4:0] ra, input logic [15:0] wd);
    logic [15:0] unused;
    sta.frame(pxs_pkg::OP_WRITE, STRAP, ra, wd, unused);
  endtask

  task automatic t_reset_vals();
    rd_reg(pxs_pkg::REG_NPAGE, rd);
    check("page code at reset", rd, 16'h0000);
    rd_reg(pxs_pkg::REG_EXT_CTRL, rd);
    check("ext control at reset", rd, {5'h00, STRAP, 6'h00});
    rd_reg(pxs_pkg::REG_QPOLL, rd);
    check("progress at reset", rd, 16'h0000);
  endtask

  task automatic t_page();
    page_code = 4'hA;
    page_load = 1'b1;
    @(negedge clk);
    page_load = 1'b0;
    page_code = 4'h3;
    wr_reg(pxs_pkg::REG_NPAGE, 16'hFFFF);
    rd_reg(pxs_pkg::REG_NPAGE, rd);
    check("page code held", rd, 16'h000A);
  endtask

  task automatic t_reserved();
    for (int r = 9; r <= 15; r++) begin
      wr_reg(5'(r), 16'hFFFF);
      rd_reg(5'(r), rd);
      check("reserved reads zero", rd, 16'h0000);
    end
  endtask

  task automatic t_speed_duplex();
    for (int k = 0; k < 4; k++) begin
      speed_100 = k[1];
      full_duplex = k[0];
      repeat (3) @(negedge clk);
      rd_reg(pxs_pkg::REG_QPOLL, rd);
      check("speed and duplex", rd, {k[1], k[0], 14'h0000});
    end
  endtask

  // a short excursion of the live code must still be seen once
  task automatic t_progress();
    an_progress = 3'h5;
    repeat (3) @(negedge clk);
    an_progress = 3'h0;
    repeat (3) @(negedge clk);
    rd_reg(pxs_pkg::REG_QPOLL, rd);
    check("latched progress", rd, {2'b11, 3'h5, 11'h000});
  endtask

  task automatic t_override();
    pulses = 0;
    wr_reg(pxs_pkg::REG_EXT_CTRL, 16'h8000);
    repeat (4) @(negedge clk);
    check("override pulses", 16'(pulses), 16'h0001);
    rd_reg(pxs_pkg::REG_EXT_CTRL, rd);
    check("override cleared", rd, {5'h00, STRAP, 6'h00});
    pulses = 0;
    wr_reg(pxs_pkg::REG_EXT_CTRL, 16'h0000);
    repeat (4) @(negedge clk);
    check("no override pulse", 16'(pulses), 16'h0000);
  endtask

  // a reset in mid-run clears the page code and captures the strap again
  task automatic t_mid_reset();
    reset = 1'b1;
    repeat (8) @(negedge clk);
    reset = 1'b0;
    repeat (2) @(negedge clk);
    rd_reg(pxs_pkg::REG_NPAGE, rd);
    check("page code after reset", rd, 16'h0000);
    rd_reg(pxs_pkg::REG_EXT_CTRL, rd);
    check("ext control after reset", rd, {5'h00, STRAP, 6'h00});
  endtask

  initial begin
    repeat (8) @(negedge clk);
    reset = 1'b0;
    repeat (2) @(negedge clk);
    t_reset_vals();
    t_page();
    t_reserved();
    t_speed_duplex();
    t_progress();
    t_override();
    t_mid_reset();
    close_out();
  end
endmodule

//--- hdl/pxs_mdio_engine.sv
// serial management frame engine: preamble, header, turnaround, data
// assumes mdc edges and mdio data are already synchronised to clk
`timescale 1ns/1ps
module pxs_mdio_engine (
  input wire logic clk,
  input wire logic reset,
  input wire logic mdc_rise,
  input wire logic mdc_fall,
  input wire logic mdio_bit,
  input wire logic [pxs_pkg::ADDR_W-1:0] phy_addr,
  output logic mdio_out,
  output logic mdio_oe_n,
  pxs_mgmt_if.engine m
);
  localparam int PXS_PRE_W = pxs_pkg::PRE_CNT_W;
  // header layout: start bit on top, then opcode, device address, register address
  localparam int HDR_START_BIT = pxs_pkg::HDR_BITS - 1;
  localparam int HDR_OP_LSB = HDR_START_BIT - 2;
  localparam int HDR_DEV_LSB = pxs_pkg::ADDR_W;
  pxs_pkg::pxs_state_e state;
  logic [PXS_PRE_W-1:0] pre_cnt;
  logic [pxs_pkg::HDR_BITS-1:0] hdr;
  logic [pxs_pkg::HDR_BITS-1:0] next_hdr;
  logic [3:0] hcnt;
  logic [pxs_pkg::RISE_CNT_W-1:0] rcnt;
  logic [pxs_pkg::DATA_W-1:0] sh;

  assign next_hdr = {hdr[pxs_pkg::HDR_BITS-2:0], mdio_bit};

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= pxs_pkg::S_PRE;
      pre_cnt <= '0;
      hdr <= '0;
      hcnt <= '0;
      rcnt <= '0;
      sh <= '0;
      m.rd_req <= 1'b0;
      m.wr_req <= 1'b0;
      m.addr <= '0;
      m.wdata <= '0;
      mdio_out <= 1'b1;
      mdio_oe_n <= 1'b1;
    end else begin
      m.rd_req <= 1'b0;
      m.wr_req <= 1'b0;
      if (mdc_rise) begin
        unique case (state)
          pxs_pkg::S_PRE: begin
            if (mdio_bit) begin
              if (pre_cnt != pxs_pkg::PRE_FULL) begin
                pre_cnt <= pre_cnt + 1'b1;
              end
            end else if (pre_cnt == pxs_pkg::PRE_FULL) begin
              state <= pxs_pkg::S_HDR;
              hcnt <= '0;
              hdr <= '0;
              pre_cnt <= '0;
            end else begin
              pre_cnt <= '0;
            end
          end
          pxs_pkg::S_HDR: begin
            hdr <= next_hdr;
            hcnt <= hcnt + 1'b1;
            if (hcnt == 4'(pxs_pkg::HDR_BITS - 1)) begin
              rcnt <= '0;
              m.addr <= next_hdr[pxs_pkg::ADDR_W-1:0];
              // a frame for another address or a bad start needs a fresh preamble
              if (!next_hdr[HDR_START_BIT] ||
                  next_hdr[HDR_DEV_LSB +: pxs_pkg::ADDR_W] != phy_addr) begin
                state <= pxs_pkg::S_PRE;
              end else if (next_hdr[HDR_OP_LSB +: 2] == pxs_pkg::OP_READ) begin
                state <= pxs_pkg::S_RD;
                m.rd_req <= 1'b1;
              end else if (next_hdr[HDR_OP_LSB +: 2] == pxs_pkg::OP_WRITE) begin
                state <= pxs_pkg::S_WR;
              end else begin
                state <= pxs_pkg::S_PRE;
              end
            end
          end
          pxs_pkg::S_RD: begin
            rcnt <= rcnt + 1'b1;
          end
          pxs_pkg::S_WR: begin
            rcnt <= rcnt + 1'b1;
            sh <= {sh[pxs_pkg::DATA_W-2:0], mdio_bit};
            if (rcnt == pxs_pkg::RISE_DATA_LAST) begin
              m.wdata <= {sh[pxs_pkg::DATA_W-2:0], mdio_bit};
              m.wr_req <= 1'b1;
              state <= pxs_pkg::S_PRE;
            end
          end
        endcase
      end
      // read data changes on the falling edge so the host samples it stable
      if (mdc_fall && state == pxs_pkg::S_RD) begin
        if (rcnt == pxs_pkg::RISE_TA_END) begin
          mdio_oe_n <= 1'b0;
          mdio_out <= 1'b0;
          sh <= m.rdata;
        end else if (rcnt == pxs_pkg::RISE_DONE) begin
          mdio_oe_n <= 1'b1;
          mdio_out <= 1'b1;
          state <= pxs_pkg::S_PRE;
        end else if (rcnt > pxs_pkg::RISE_TA_END) begin
          mdio_out <= sh[pxs_pkg::DATA_W-1];
          sh <= {sh[pxs_pkg::DATA_W-2:0], 1'b0};
        end
      end
    end
  end
endmodule

//--- hdl/pxs_status_regs.sv
// extended status register slice of the transceiver management bank
// assumes status inputs come from logic on clk; mdc, mdio and address straps are pins
//
// Behaviour
// - partner_next_page_ability bits 3:0 read-only partner page code, reset zero.
// - addresses 9 to 15 are reserved; they read zero, writes ignored.
// - quick_poll_status bit 15 reports speed: 0 is 10 Mbps, 1 is 100 Mbps.
// - quick_poll_status bit 14 reports duplex: 1 full, 0 half (unsupported).
// - three-bit progress code latched, bits 13:12 upper, reset zero, read-only.
// - extended_control bit 15 override write enable, read-write, self_clearing.
`timescale 1ns/1ps
module pxs_status_regs (
  input wire logic clk,
  input wire logic reset,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_n,
  input wire logic [pxs_pkg::ADDR_W-1:0] phy_addr_strap,
  input wire logic page_load,
  input wire logic [pxs_pkg::NP_CODE_W-1:0] page_code,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic [2:0] an_progress,
  output logic cmd_override_en
);
  pxs_mgmt_if m ();

  logic mdc_s1;
  logic mdc_s2;
  logic mdc_s3;
  logic mdio_s1;
  logic mdio_s2;
  logic [pxs_pkg::ADDR_W-1:0] strap_s1;
  logic [pxs_pkg::ADDR_W-1:0] strap_s2;
  logic [pxs_pkg::ADDR_W-1:0] phy_addr;
  logic [pxs_pkg::NP_CODE_W-1:0] np_code;
  logic [2:0] lat_prog;
  logic lat_hold;
  logic rd_qpoll;
  logic wr_ovr;

  function automatic logic hits(input logic [pxs_pkg::ADDR_W-1:0] a,
                                input logic [pxs_pkg::ADDR_W-1:0] r);
    return a == r;
  endfunction

  // pins cross into clk through two flops before anything reads them
  always_ff @(posedge clk) begin
    mdc_s1 <= mdc;
    mdc_s2 <= mdc_s1;
    mdc_s3 <= mdc_s2;
    mdio_s1 <= mdio_in;
    mdio_s2 <= mdio_s1;
    strap_s1 <= phy_addr_strap;
    strap_s2 <= strap_s1;
  end

  // straps are caught while reset is held and frozen afterwards
  always_ff @(posedge clk) begin
    if (reset) begin
      phy_addr <= strap_s2;
    end
  end

  pxs_mdio_engine u_engine (
    .clk(clk),
    .reset(reset),
    .mdc_rise(mdc_s2 & ~mdc_s3),
    .mdc_fall(~mdc_s2 & mdc_s3),
    .mdio_bit(mdio_s2),
    .phy_addr(phy_addr),
    .mdio_out(mdio_out),
    .mdio_oe_n(mdio_oe_n),
    .m(m.engine)
  );

  assign rd_qpoll = m.rd_req && hits(m.addr, pxs_pkg::REG_QPOLL);
  assign wr_ovr = m.wr_req && hits(m.addr, pxs_pkg::REG_EXT_CTRL) && m.wdata[pxs_pkg::EXT_OVR_BIT];

  // partner code only moves when a page arrives; management writes never touch it
  always_ff @(posedge clk) begin
    if (reset) begin
      np_code <= pxs_pkg::NP_CODE_RESET;
    end else if (page_load) begin
      np_code <= page_code;
    end
  end

  // a change is held until the register is read; a change during the read wins
  always_ff @(posedge clk) begin
    if (reset) begin
      lat_prog <= pxs_pkg::PROG_RESET;
      lat_hold <= 1'b0;
    end else if (an_progress != lat_prog && (!lat_hold || rd_qpoll)) begin
      lat_prog <= an_progress;
      lat_hold <= 1'b1;
    end else if (rd_qpoll) begin
      lat_hold <= 1'b0;
    end
  end

  // one-cycle enable, then clears itself
  always_ff @(posedge clk) begin
    if (reset) begin
      cmd_override_en <= 1'b0;
    end else begin
      cmd_override_en <= wr_ovr;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      m.rdata <= '0;
    end else if (m.rd_req) begin
      m.rdata <= '0;
      if (hits(m.addr, pxs_pkg::REG_NPAGE)) begin
        m.rdata[pxs_pkg::NP_CODE_W-1:0] <= np_code;
      end else if (hits(m.addr, pxs_pkg::REG_EXT_CTRL)) begin
        m.rdata[pxs_pkg::EXT_OVR_BIT] <= cmd_override_en;
        m.rdata[pxs_pkg::EXT_ADDR_LSB +: pxs_pkg::ADDR_W] <= phy_addr;
      end else if (rd_qpoll) begin
        m.rdata[pxs_pkg::QP_SPEED_BIT] <= speed_100;
        m.rdata[pxs_pkg::QP_DUPLEX_BIT] <= full_duplex;
        m.rdata[pxs_pkg::QP_PROG_HI_LSB +: 2] <= lat_prog[2:1];
        m.rdata[pxs_pkg::QP_PROG_LO_BIT] <= lat_prog[0];
      end
      // reserved 9..15 and every other address fall through as zero
    end
  end

  npage_load_a: assert property (
    @(posedge clk) disable iff (reset)
    page_load |=> np_code == $past(page_code))
    else $error("partner page code not loaded");

  reserved_read_a: assert property (
    @(posedge clk) disable iff (reset)
    m.rd_req && m.addr >= pxs_pkg::REG_RSV_LO && m.addr <= pxs_pkg::REG_RSV_HI
    |=> m.rdata == '0)
    else $error("reserved register read nonzero");

  speed_report_a: assert property (
    @(posedge clk) disable iff (reset)
    rd_qpoll |=> m.rdata[pxs_pkg::QP_SPEED_BIT] == $past(speed_100))
    else $error("speed bit mismatch");

  duplex_report_a: assert property (
    @(posedge clk) disable iff (reset)
    rd_qpoll |=> m.rdata[pxs_pkg::QP_DUPLEX_BIT] == $past(full_duplex))
    else $error("duplex bit mismatch");

  progress_hold_a: assert property (
    @(posedge clk) disable iff (reset)
    lat_hold && !rd_qpoll |=> $stable(lat_prog) && lat_hold)
    else $error("latched progress moved while held");

  override_clear_a: assert property (
    @(posedge clk) disable iff (reset)
    wr_ovr |=> cmd_override_en ##1 !cmd_override_en)
    else $error("override enable did not self-clear");

  override_quiet_a: assert property (
    @(posedge clk) disable iff (reset)
    !wr_ovr |=> !cmd_override_en)
    else $error("override enable without a write");

  override_read_a: assert property (
    @(posedge clk) disable iff (reset)
    m.rd_req && hits(m.addr, pxs_pkg::REG_EXT_CTRL)
    |=> m.rdata[pxs_pkg::EXT_OVR_BIT] == $past(cmd_override_en))
    else $error("override bit read mismatch");

  npage_hold_a: assert property (
    @(posedge clk) disable iff (reset)
    !page_load |=> $stable(np_code))
    else $error("partner page code moved without a page");

  npage_read_a: assert property (
    @(posedge clk) disable iff (reset)
    m.rd_req && hits(m.addr, pxs_pkg::REG_NPAGE)
    |=> m.rdata[pxs_pkg::NP_CODE_W-1:0] == $past(np_code)
    && m.rdata[pxs_pkg::DATA_W-1:pxs_pkg::NP_CODE_W] == '0)
    else $error("partner page code read mismatch");

  unmapped_read_a: assert property (
    @(posedge clk) disable iff (reset)
    m.rd_req && !hits(m.addr, pxs_pkg::REG_NPAGE) && !hits(m.addr, pxs_pkg::REG_EXT_CTRL)
    && !hits(m.addr, pxs_pkg::REG_QPOLL) |=> m.rdata == '0)
    else $error("unmapped register read nonzero");

  progress_read_a: assert property (
    @(posedge clk) disable iff (reset)
    rd_qpoll |=> m.rdata[pxs_pkg::QP_PROG_HI_LSB +: 2] == $past(lat_prog[2:1])
    && m.rdata[pxs_pkg::QP_PROG_LO_BIT] == $past(lat_prog[0]))
    else $error("progress code read mismatch");

  progress_catch_a: assert property (
    @(posedge clk) disable iff (reset)
    !lat_hold && an_progress != lat_prog |=> lat_hold && lat_prog == $past(an_progress))
    else $error("progress change not latched");

  progress_release_a: assert property (
    @(posedge clk) disable iff (reset)
    rd_qpoll && an_progress == lat_prog |=> !lat_hold)
    else $error("progress latch not released by read");

  // no disable here: these look at what reset itself leaves behind
  reset_quiet_a: assert property (
    @(posedge clk)
    reset |=> !cmd_override_en && mdio_oe_n && mdio_out)
    else $error("outputs not idle after reset");

  reset_clear_a: assert property (
    @(posedge clk)
    reset |=> np_code == pxs_pkg::NP_CODE_RESET && lat_prog == pxs_pkg::PROG_RESET)
    else $error("page or progress code not cleared by reset");
endmodule

//--- pkg/pxs_mgmt_if.sv
// register access strobes between the serial engine and the register bank
// assumes both ends sit on the same clock
`timescale 1ns/1ps
interface pxs_mgmt_if;
  logic rd_req;
  logic wr_req;
  logic [pxs_pkg::ADDR_W-1:0] addr;
  logic [pxs_pkg::DATA_W-1:0] wdata;
  logic [pxs_pkg::DATA_W-1:0] rdata;
  modport engine (output rd_req, output wr_req, output addr, output wdata, input rdata);
  modport bank (input rd_req, input wr_req, input addr, input wdata, output rdata);
endinterface

//--- pkg/pxs_pkg.sv
// constants, field layout and state type of the extended status register slice
// assumes one 40 MHz clock; the management clock pin is sampled as ordinary data
package pxs_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam int PRE_LEN = 32;
  localparam int HDR_BITS = 13;
  localparam int PRE_CNT_W = 6;
  localparam int RISE_CNT_W = 5;
  // rise counts inside the data phase: two turnaround bits, then sixteen data bits
  localparam logic [RISE_CNT_W-1:0] RISE_TA_END = 5'h01;
  localparam logic [RISE_CNT_W-1:0] RISE_DATA_LAST = 5'h11;
  localparam logic [RISE_CNT_W-1:0] RISE_DONE = 5'h12;
  localparam logic [PRE_CNT_W-1:0] PRE_FULL = 6'h20;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;

  localparam logic [ADDR_W-1:0] REG_NPAGE = 5'h08;
  localparam logic [ADDR_W-1:0] REG_RSV_LO = 5'h09;
  localparam logic [ADDR_W-1:0] REG_RSV_HI = 5'h0F;
  localparam logic [ADDR_W-1:0] REG_EXT_CTRL = 5'h10;
  localparam logic [ADDR_W-1:0] REG_QPOLL = 5'h11;

  localparam int NP_CODE_W = 4;
  localparam logic [NP_CODE_W-1:0] NP_CODE_RESET = 4'h0;
  localparam int EXT_OVR_BIT = 15;
  localparam int EXT_ADDR_LSB = 6;
  localparam int QP_SPEED_BIT = 15;
  localparam int QP_DUPLEX_BIT = 14;
  localparam int QP_PROG_HI_LSB = 12;
  localparam int QP_PROG_LO_BIT = 11;
  localparam logic [2:0] PROG_RESET = 3'h0;

  typedef enum logic [1:0] {S_PRE, S_HDR, S_RD, S_WR} pxs_state_e;
endpackage
